// ===== verilog/fdpc_defs.vh
// Constants for the flash data page controller
`ifndef FDPC_DEFS_VH
`define FDPC_DEFS_VH
`define FDPC_CMD_READ 8'h01
`define FDPC_CMD_PROGRAM 8'h02
`define FDPC_CMD_VERIFY 8'h04
`define FDPC_CMD_ERASE 8'h05
`define FDPC_CMD_ERASE_ALL 8'h06
`define FDPC_PAGES 160
`define FDPC_LAST_PAGE 8'h9f
`define FDPC_ERASED_BYTE 8'hff
`define FDPC_CLK_MHZ 125
`define FDPC_ERASE_US 20000
`define FDPC_PROG_US 250
`define FDPC_ERASE_CYC (`FDPC_ERASE_US * `FDPC_CLK_MHZ)
`define FDPC_PROG_CYC (`FDPC_PROG_US * `FDPC_CLK_MHZ)
`define FDPC_ST_IDLE 3'h0
`define FDPC_ST_READ 3'h1
`define FDPC_ST_PROG 3'h2
`define FDPC_ST_VERIFY 3'h3
`define FDPC_ST_ERASE 3'h4
`define FDPC_ST_WAIT 3'h5
`define FDPC_ST_ERALL 3'h6
`endif

// ===== verilog/fdpc_page_mem.v
// Page-wide storage array with registered read data
`timescale 1ns/1ps
module fdpc_page_mem #(
    parameter DEPTH = 160, // Number of pages
    parameter AW = 8 // Page address width
) (
    input wire clock, // System clock
    input wire wrEn, // Write the addressed page
    input wire [AW-1:0] addr, // Page address
    input wire [31:0] wrData, // Page write data
    output reg [31:0] rdData_r // Registered page read data
);
    reg [31:0] mem [0:DEPTH-1];
    always @(posedge clock) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
        rdData_r <= mem[addr];
    end
endmodule // fdpc_page_mem

// ===== verilog/fdpc_controller.v
// Command-driven controller for the nonvolatile data page array
`timescale 1ns/1ps
`include "fdpc_defs.vh"
// How it works
// - A read command copies the addressed page into the four data bytes.
// - A program command writes the four data bytes to the addressed page.
// - Programming can only clear bits, so the page must be erased first.
// - Verify compares data bytes with the page; command reads zero on match.
// - Page erase clears only the addressed four-byte page to ones.
// - Erase-all sets every one of the 160 pages to ones.
// - Erased bytes read all ones; only erased bits can be programmed.
// - An operation starts on the very write of the command byte.
// - The core is stalled until the operation has finished.
// - Timers keep running while the core is stalled.
// - Erases take 20 ms and a page program 250 us.
// - A page read completes within one instruction cycle.
// - The page address selects one of pages 00 to 9f.
module fdpc_controller #(
    parameter PAGES = `FDPC_PAGES, // Number of four-byte pages
    parameter ERASE_CYCLES = `FDPC_ERASE_CYC, // Erase duration in cycles
    parameter PROG_CYCLES = `FDPC_PROG_CYC // Program duration in cycles
) (
    input wire clock, // System clock
    input wire sys_rst, // Synchronous reset, active high
    input wire addrWrite, // Write strobe for page address register
    input wire [7:0] addrIn, // Page address write data
    input wire [3:0] dataWrite, // Write strobes for data bytes one to four
    input wire [7:0] dataIn, // Data byte write data
    input wire cmdWrite, // Write strobe for flash command register
    input wire [7:0] cmdIn, // Command byte
    output reg [7:0] pageAddress_r, // Page address register
    output reg [31:0] pageData_r, // Data bytes, byte one in bits 7:0
    output reg [7:0] flashCommand_r, // Command register read value
    output wire coreStall // High while the core must be held
);
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [24:0] timer_r;
    reg [7:0] walk_r;
    reg memWe;
    reg [7:0] memAddr;
    reg [31:0] memWd;
    wire [31:0] memRd;
    wire addrOk = (pageAddress_r <= `FDPC_LAST_PAGE);

    fdpc_page_mem #(.DEPTH(PAGES), .AW(8)) u_mem (
        .clock(clock),
        .wrEn(memWe),
        .addr(memAddr),
        .wrData(memWd),
        .rdData_r(memRd)
    );

    // Stall from command write to finish
    // Combinational so the stall covers the write cycle itself
    assign coreStall = (state_r != `FDPC_ST_IDLE) || cmdWrite;

    always @* begin
        memWe = 1'b0;
        memAddr = pageAddress_r;
        memWd = pageData_r;
        state_nxt = state_r;
        case (state_r)
            `FDPC_ST_IDLE: begin
                if (cmdWrite && addrOk) begin
                    case (cmdIn)
                        `FDPC_CMD_READ: begin
                            state_nxt = `FDPC_ST_READ;
                        end
                        `FDPC_CMD_PROGRAM: begin
                            state_nxt = `FDPC_ST_PROG;
                        end
                        `FDPC_CMD_VERIFY: begin
                            state_nxt = `FDPC_ST_VERIFY;
                        end
                        `FDPC_CMD_ERASE: begin
                            state_nxt = `FDPC_ST_ERASE;
                        end
                        `FDPC_CMD_ERASE_ALL: begin
                            state_nxt = `FDPC_ST_ERALL;
                        end
                        default: begin
                            state_nxt = `FDPC_ST_IDLE;
                        end
                    endcase
                end else if (cmdWrite && cmdIn == `FDPC_CMD_ERASE_ALL) begin
                    // Erase-all does not depend on the page address
                    state_nxt = `FDPC_ST_ERALL;
                end
            end
            `FDPC_ST_READ: begin
                state_nxt = `FDPC_ST_IDLE;
            end
            `FDPC_ST_VERIFY: begin
                state_nxt = `FDPC_ST_IDLE;
            end
            `FDPC_ST_PROG: begin
                memWe = 1'b1;
                memWd = memRd & pageData_r;
                state_nxt = `FDPC_ST_WAIT;
            end
            `FDPC_ST_ERASE: begin
                memWe = 1'b1;
                memWd = {4{`FDPC_ERASED_BYTE}};
                state_nxt = `FDPC_ST_WAIT;
            end
            `FDPC_ST_ERALL: begin
                memWe = 1'b1;
                memAddr = walk_r;
                memWd = {4{`FDPC_ERASED_BYTE}};
                if (walk_r == PAGES - 1) begin
                    state_nxt = `FDPC_ST_WAIT;
                end
            end
            `FDPC_ST_WAIT: begin
                if (timer_r == 25'h0000000) begin
                    state_nxt = `FDPC_ST_IDLE;
                end
            end
            default: begin
                state_nxt = `FDPC_ST_IDLE;
            end
        endcase
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            state_r <= `FDPC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Any byte stored, range checked at use
    always @(posedge clock) begin
        if (sys_rst) begin
            pageAddress_r <= 8'h00;
        end else if (addrWrite && state_r == `FDPC_ST_IDLE) begin
            pageAddress_r <= addrIn;
        end
    end

    // Writes while busy are dropped so the page in flight stays intact
    always @(posedge clock) begin
        if (sys_rst) begin
            pageData_r <= 32'h00000000;
        end else if (state_r == `FDPC_ST_IDLE) begin
            if (dataWrite[0]) begin
                pageData_r[7:0] <= dataIn;
            end
            if (dataWrite[1]) begin
                pageData_r[15:8] <= dataIn;
            end
            if (dataWrite[2]) begin
                pageData_r[23:16] <= dataIn;
            end
            if (dataWrite[3]) begin
                pageData_r[31:24] <= dataIn;
            end
        end else if (state_r == `FDPC_ST_READ) begin
            pageData_r <= memRd;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            flashCommand_r <= 8'h00;
        end else if (state_r == `FDPC_ST_IDLE && cmdWrite) begin
            flashCommand_r <= cmdIn;
        end else if (state_r == `FDPC_ST_VERIFY) begin
            flashCommand_r <= (memRd == pageData_r) ? 8'h00 : 8'h01;
        end
    end

    // Page counter for the erase-all walk
    always @(posedge clock) begin
        if (sys_rst) begin
            walk_r <= 8'h00;
        end else if (state_r == `FDPC_ST_ERALL) begin
            walk_r <= walk_r + 8'h01;
        end else begin
            walk_r <= 8'h00;
        end
    end

    // Busy timer; erase-all walk overlaps its own erase time
    always @(posedge clock) begin
        if (sys_rst) begin
            timer_r <= 25'h0000000;
        end else if (state_r == `FDPC_ST_PROG) begin
            timer_r <= PROG_CYCLES[24:0] - 25'h0000002;
        end else if (state_r == `FDPC_ST_ERASE) begin
            timer_r <= ERASE_CYCLES[24:0] - 25'h0000002;
        end else if (state_r == `FDPC_ST_ERALL && walk_r == 8'h00) begin
            timer_r <= ERASE_CYCLES[24:0] - 25'h0000002;
        end else if (timer_r != 25'h0000000) begin
            timer_r <= timer_r - 25'h0000001;
        end
    end
    // No timer gating; only the core stalls
endmodule // fdpc_controller

// ===== test/fdpc_controller_properties.sv
// Checker for the flash page controller ports
`timescale 1ns/1ps
module fdpc_controller_properties #(
    parameter PAGES = 160, // Pages
    parameter ERASE_CYCLES = 8, // Erase length
    parameter PROG_CYCLES = 4 // Program length
) (
    input wire clock, // Clock
    input wire sys_rst, // Reset
    input wire cmdWrite, // Command strobe
    input wire [7:0] cmdIn, // Command code
    input wire [7:0] pageAddress_r, // Page address
    input wire [31:0] pageData_r, // Page data
    input wire [7:0] flashCommand_r, // Command readback
    input wire coreStall // Core hold
);
    reg prevStall_r = 1'b0;
    // Writes while held are ignored, so only idle writes count
    wire take = cmdWrite && !prevStall_r;
    wire okPage = pageAddress_r <= 8'h9f;
    always @(posedge clock) prevStall_r <= coreStall;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence held_s; coreStall ##1 coreStall; endsequence
    sequence quiet_s; !coreStall; endsequence
    stall_now_a: assert property (cmdWrite |-> coreStall)
        else $error("no stall on command");
    read_fast_a: assert property (take && cmdIn == 8'h01 && okPage
        |-> ##2 quiet_s) else $error("read too slow");
    prog_time_a: assert property (take && cmdIn == 8'h02 && okPage
        |-> ##1 held_s ##[1:20] quiet_s) else $error("program length");
    erase_time_a: assert property (take && cmdIn == 8'h05 && okPage
        |-> ##1 held_s ##1 held_s ##1 held_s
        ##[1:40] quiet_s) else $error("erase length");
    erase_all_a: assert property (take && cmdIn == 8'h06
        |-> ##1 held_s ##[150:200] quiet_s) else $error("erase-all length");
    verify_code_a: assert property (take && cmdIn == 8'h04 && okPage
        |-> ##2 flashCommand_r <= 8'h01) else $error("verify result");
    cmd_keep_a: assert property (take && cmdIn != 8'h04
        |=> flashCommand_r == $past(cmdIn)) else $error("command lost");
    busy_hold_a: assert property (coreStall && !cmdWrite
        |=> $stable(pageAddress_r)) else $error("address moved");
    reserved_keep_a: assert property (take && !(cmdIn inside
        {8'h01, 8'h02, 8'h04, 8'h05, 8'h06}) |=> $stable(pageData_r)[*3])
        else $error("reserved code acted");
endmodule // fdpc_controller_properties
bind fdpc_controller fdpc_controller_properties #(.PAGES(PAGES),
    .ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES))
    fdpc_controller_properties_inst (.clock(clock), .sys_rst(sys_rst),
    .cmdWrite(cmdWrite), .cmdIn(cmdIn), .pageAddress_r(pageAddress_r),
    .pageData_r(pageData_r), .flashCommand_r(flashCommand_r),
    .coreStall(coreStall));

// ===== test/fdpc_core_model.sv
// Core-side model issuing register writes
`timescale 1ns/1ps
module fdpc_core_model (
    input wire clock, // Clock
    input wire coreStall, // Core held
    output reg addrWrite = 1'b0, // Address strobe
    output reg [3:0] dataWrite = 4'h0, // Data strobes
    output reg cmdWrite = 1'b0, // Command strobe
    output reg [7:0] busData = 8'h00 // Shared write data
);
    integer hangs = 0;
    task settle;
        integer n;
        begin
            // Erase-all walks every page, so allow well past 160 cycles
            for (n = 0; n < 999 && coreStall !== 1'b0; n = n + 1) begin
                @(posedge clock);
                #1;
            end
            if (coreStall !== 1'b0) hangs = hangs + 1;
        end
    endtask
    task put(input [5:0] sel, input [7:0] val);
        begin
            settle;
            @(posedge clock);
            busData <= val;
            {cmdWrite, dataWrite, addrWrite} <= sel;
            @(posedge clock);
            {cmdWrite, dataWrite, addrWrite} <= 6'h00;
            #1;
            settle;
        end
    endtask
endmodule // fdpc_core_model

// ===== test/flash_data_page_controller_test.sv
// Self-checking bench for the flash page controller
`timescale 1ns/1ps
module flash_data_page_controller_test;
    reg clock = 1'b0;
    reg sys_rst = 1'b1;
    wire addrWrite, cmdWrite, coreStall;
    wire [3:0] dataWrite;
    wire [7:0] busData, pageAddress_r, flashCommand_r;
    wire [31:0] pageData_r;
    integer fail_count = 0;
    integer n_compared = 0;
    integer i;
    initial forever #4 clock = ~clock;
    fdpc_controller #(.PROG_CYCLES(4), .ERASE_CYCLES(8)) fdpc_controller_inst (
        .clock(clock), .sys_rst(sys_rst), .addrWrite(addrWrite),
        .addrIn(busData), .dataWrite(dataWrite), .dataIn(busData),
        .cmdWrite(cmdWrite), .cmdIn(busData), .pageAddress_r(pageAddress_r),
        .pageData_r(pageData_r), .flashCommand_r(flashCommand_r),
        .coreStall(coreStall));
    fdpc_core_model fdpc_core_model_inst (.clock(clock),
        .coreStall(coreStall), .addrWrite(addrWrite), .dataWrite(dataWrite),
        .cmdWrite(cmdWrite), .busData(busData));
    task chk(input [8*5:1] what, input [31:0] exp, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task run(input [7:0] page, input [7:0] code, input [31:0] d);
        begin
            fdpc_core_model_inst.put(6'h01, page);
            for (i = 0; i < 4 && (code == 8'h02 || code == 8'h04); i = i + 1)
                fdpc_core_model_inst.put(6'h02 << i, d[8*i +: 8]);
            fdpc_core_model_inst.put(6'h20, code);
        end
    endtask
    task rd(input [7:0] page, input [31:0] exp);
        begin
            run(page, 8'h01, 32'h0);
            chk("page", exp, pageData_r);
        end
    endtask
    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        chk("reset", 32'h0, pageData_r | {pageAddress_r, flashCommand_r,
            15'h0, coreStall});
        $display("test reset done");
        run(8'h00, 8'h06, 32'h0);
        rd(8'h9f, 32'hffffffff);
        run(8'h02, 8'h02, 32'h78563412);
        run(8'h03, 8'h02, 32'h78563412);
        run(8'h03, 8'h04, 32'h0);
        chk("vfail", 32'h01, flashCommand_r);
        rd(8'h03, 32'h78563412);
        run(8'h03, 8'h04, 32'h78563412);
        chk("vpass", 32'h0, flashCommand_r);
        $display("test program done");
        run(8'h03, 8'h02, 32'hf0f0f0f0);
        rd(8'h03, 32'h70503010);
        run(8'h03, 8'h05, 32'h0);
        rd(8'h03, 32'hffffffff);
        rd(8'h02, 32'h78563412);
        run(8'h02, 8'h05, 32'h0);
        run(8'h02, 8'h02, 32'h7856f312);
        rd(8'h02, 32'h7856f312);
        $display("test erase done");
        run(8'h02, 8'h03, 32'h0);
        chk("code", 32'h03, flashCommand_r);
        run(8'h02, 8'hff, 32'h0);
        chk("code", 32'hff, flashCommand_r);
        chk("data", 32'h7856f312, pageData_r);
        rd(8'ha0, 32'h7856f312);
        $display("test reserved done");
        fail_count = fail_count + fdpc_core_model_inst.hangs;
        summarize;
    end
endmodule // flash_data_page_controller_test
